//--- dv/tb_trace_capture_trigger_ctrl.sv
// Self-checking bench for the trace capture controller.
`timescale 1ns/1ps
module tb_trace_capture_trigger_ctrl;
  import trace_cap_pkg::*;
  logic        clk, rst, awv, wv, bready, arv, rready, tclk, awr, wr, bv, arr, rv, we, internal_debug_mode_bit, external_debug_mode_bit;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd, bd, last_d, v;
  logic [3:0]  bp;
  logic [2:0]  ev;
  logic [23:0] td;
  logic [1:0]  br, rr, r;
  logic [16:0] ba;
  int          fails, num_checks, nwr, n0;

  trace_capture_ctrl uut (.REF_CLK(clk), .RESET(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
    .TRACE_CLK(tclk), .TRACE_DATA(td), .BP_MATCH(bp), .EVT_IRQ(ev[0]), .EVT_LR(ev[1]), .EVT_PID(ev[2]),
    .BUF_WE(we), .BUF_ADDR(ba), .BUF_DATA(bd), .INTERNAL_DEBUG_MODE_BIT(internal_debug_mode_bit), .EXTERNAL_DEBUG_MODE_BIT(external_debug_mode_bit));
  trace_src trc (.trace_clk(tclk), .trace_data(td), .bp_match(bp), .evt(ev));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Counts buffer writes and keeps the last record.
  always @(posedge clk) begin
    if (we === 1'b1) begin
      nwr <= nwr + 1;
      last_d <= bd;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    int   n;
    logic ta, tw;
    n = 0;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (!ta && awr === 1'b1) begin
        ta = 1'b1;
        awv <= 1'b0;
      end
      if (!tw && wr === 1'b1) begin
        tw = 1'b1;
        wv <= 1'b0;
      end
    end while (!(ta && tw && bv === 1'b1));
    rs = br;
    bready <= 1'b0;
    chk(n < 100, 1, "write answer");
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    int   n;
    logic t;
    n = 0;
    t = 1'b0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (!t && arr === 1'b1) begin
        t = 1'b1;
        arv <= 1'b0;
      end
    end while (!(t && rv === 1'b1));
    d = rd;
    rs = rr;
    rready <= 1'b0;
    chk(n < 100, 1, "read answer");
  endtask : axr

  function automatic logic [31:0] pt(input logic [2:0] k);
    return {27'h0, 1'b0, k, 1'b1};
  endfunction : pt

  task automatic rec(input logic [23:0] d, input logic [3:0] m);
    trc.send(d, m, 3'h0);
    repeat (2) @(posedge clk);
  endtask : rec

  task automatic t_regs;
    axr(CTRL_OFS, v, r);
    chk(v, CTRL_RESET, "ctrl reset");
    chk({30'h0, internal_debug_mode_bit, external_debug_mode_bit}, 32'h0000_0003, "debug bits at reset");
    axw(AFTER_OFS, 32'h0001_FFFF, r);
    axr(AFTER_OFS, v, r);
    chk(v, {16'h0, COUNT_MAX}, "after count");
    axr(8'h40, v, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped");
    $display("test regs done");
  endtask : t_regs

  task automatic t_events;
    n0 = nwr;
    trc.send(24'hA5_5A01, 4'h0, 3'h7);
    repeat (2) @(posedge clk);
    chk(last_d, 32'h38A5_5A01, "all event marks");
    trc.send(24'h00_00C3, 4'h0, 3'h1);
    repeat (2) @(posedge clk);
    chk(last_d, 32'h0800_00C3, "interrupt mark");
    chk(nwr - n0, 2, "one record per edge");
    $display("test events done");
  endtask : t_events

  task automatic t_begin_halt;
    axw(AFTER_OFS, 32'h0000_0002, r);
    axw(POINT_OFS, pt(KIND_BEGIN), r);
    axw(POINT_OFS + 8'h04, pt(KIND_HALT), r);
    axw(CTRL_OFS, 32'h0000_0019, r);
    chk({30'h0, internal_debug_mode_bit, external_debug_mode_bit}, 32'h0000_0000, "debug bits armed");
    n0 = nwr;
    rec(24'h00_0001, 4'h0);
    chk(nwr - n0, 0, "off before begin");
    rec(24'h00_0002, 4'h1);
    chk(last_d, 32'h8000_0002, "begin record");
    for (int i = 0; i < 32; i++) rec(i[23:0], 4'h0);
    rec(24'h00_0003, 4'h2);
    repeat (3) rec(24'h00_0004, 4'h0);
    chk(nwr - n0, 36, "begin to halt span");
    n0 = nwr;
    rec(24'h00_0005, 4'h2);
    chk(nwr - n0, 1, "first event is begin");
    axr(STATUS_OFS, v, r);
    chk({29'h0, v[2:0]}, 32'h0000_0001, "running");
    $display("test begin halt done");
  endtask : t_begin_halt

  task automatic t_single;
    axw(POINT_OFS, 32'h0000_0000, r);
    axw(POINT_OFS + 8'h04, pt(KIND_REPORT), r);
    axw(POINT_OFS + 8'h08, pt(KIND_SINGLE), r);
    axw(AFTER_OFS, 32'h0000_0001, r);
    axw(CTRL_OFS, 32'h0000_0019, r);
    n0 = nwr;
    rec(24'h00_0006, 4'h0);
    rec(24'h00_0005, 4'h2);
    chk(last_d, 32'hC000_0005, "report pattern");
    rec(24'h00_0007, 4'h4);
    repeat (3) rec(24'h00_0008, 4'h0);
    chk(nwr - n0, 3, "report plus single hit plus one");
    $display("test single done");
  endtask : t_single

  task automatic t_freeze;
    axw(POINT_OFS + 8'h08, 32'h0000_0000, r);
    axw(POINT_OFS + 8'h0C, pt(KIND_FREEZE), r);
    axw(TAIL_OFS, 32'h0000_0000, r);
    axw(CTRL_OFS, 32'h0000_0019, r);
    n0 = nwr;
    rec(24'h00_0009, 4'h8);
    repeat (18) rec(24'h00_000A, 4'h0);
    chk(nwr - n0, 17, "tail forced to 16");
    rec(24'h00_000B, 4'h8);
    chk(nwr - n0, 17, "stays frozen");
    axr(STATUS_OFS, v, r);
    chk({29'h0, v[2:0]}, 32'h0000_0004, "frozen state");
    axw(CTRL_OFS, 32'h0000_0019, r);
    rec(24'h00_000C, 4'h0);
    chk(nwr - n0, 18, "resume rearms");
    $display("test freeze done");
  endtask : t_freeze

  task automatic t_pause;
    n0 = nwr;
    axw(CTRL_OFS, 32'h0000_001C, r);
    rec(24'h00_000D, 4'h0);
    chk(nwr - n0, 0, "paused");
    axw(CTRL_OFS, 32'h0000_0018, r);
    rec(24'h00_000E, 4'h0);
    chk(nwr - n0, 1, "earlier state kept");
    $display("test pause done");
  endtask : t_pause

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  initial begin
    rst = 1'b1;
    {awv, wv, bready, arv, rready} = '0;
    {awa, ara, wd} = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_events;
    t_begin_halt;
    t_single;
    t_freeze;
    t_pause;
    test_done;
  end

  initial begin
    #200_000;
    fails++;
    test_done;
  end
endmodule : tb_trace_capture_trigger_ctrl

//--- dv/trace_src.sv
// Behavioural model of the target processor's trace port.
`timescale 1ns/1ps
module trace_src
  import trace_cap_pkg::*;
(
  // Trace port
  output logic                               trace_clk,
  output logic [trace_cap_pkg::TDATA_W-1:0]  trace_data,
  output logic [trace_cap_pkg::NPOINT-1:0]   bp_match,
  output logic [2:0]                         evt
);
  initial begin
    trace_clk = 1'b0;
    trace_data = '0;
    bp_match = '0;
    evt = '0;
  end

  // One frame is one trace clock period; the clock stands still between frames.
  // Once the hold time has run out the lines show the inverse of their last value.
  // Every change lands 5 ns off the bench clock's rising edge, so none races the sampling.
  task automatic send(input logic [23:0] d, input logic [3:0] bp, input logic [2:0] ev);
    #5;
    trace_data = d;
    bp_match = bp;
    evt = ev;
    #50;
    trace_clk = 1'b1;
    #100;
    trace_clk = 1'b0;
    trace_data = ~d;
    bp_match = ~bp;
    evt = ~ev;
    #40;
  endtask : send
endmodule : trace_src

//--- inc/trace_cap_pkg.sv
// Constants, register map and types shared by the trace capture controller.
package trace_cap_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int TDATA_W = 24;
  localparam int NPOINT  = 4;
  localparam int PT_W    = 5;
  localparam int CNT_W   = 16;
  // 512 KB of 32-bit records gives 2**17 entries.
  localparam int BUF_AW  = 17;
  localparam int SYNC_W  = 1 + 3 + NPOINT + TDATA_W;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] AFTER_OFS  = 8'h08;
  localparam logic [ADDR_W-1:0] TAIL_OFS   = 8'h0C;
  localparam logic [ADDR_W-1:0] WPTR_OFS   = 8'h10;
  localparam logic [ADDR_W-1:0] POINT_OFS  = 8'h20;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int CTRL_RESUME_BIT  = 0;
  localparam int CTRL_STOPFULL_BIT = 1;
  localparam int CTRL_PAUSE_BIT   = 2;
  localparam int CTRL_IDM_BIT     = 3;
  localparam int CTRL_EDM_BIT     = 4;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0018;
  localparam int PT_EN_BIT   = 0;
  localparam int PT_KIND_LSB = 1;
  localparam int PT_DATA_BIT = 4;
  localparam logic [2:0] KIND_BEGIN  = 3'h0;
  localparam logic [2:0] KIND_HALT   = 3'h1;
  localparam logic [2:0] KIND_SINGLE = 3'h2;
  localparam logic [2:0] KIND_FREEZE = 3'h3;
  localparam logic [2:0] KIND_REPORT = 3'h4;
  localparam logic [CNT_W-1:0] COUNT_MAX  = 16'hFFFF;
  localparam logic [CNT_W-1:0] FREEZE_MIN = 16'h0010;
  localparam int REC_MATCH_BIT  = 31;
  localparam int REC_REPORT_BIT = 30;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Types
  // ****************************************
  typedef logic [NPOINT-1:0][PT_W-1:0] point_cfg_t;
  typedef enum logic [2:0] {ST_WAIT, ST_RUN, ST_TAIL, ST_STOP, ST_FROZEN} cap_state_e;

endpackage : trace_cap_pkg

//--- src/trace_capture_ctrl.sv
// Trace capture trigger controller with an AXI4-Lite register slave.
//
// Notes on behaviour
// - Capture is gated by hardware breakpoint matches, code or data, each with a kind.
// - Report-only hits store the trigger pattern flagged as matched; code breakpoints only.
// - Single-hit records the match, then records-after-hit more records, then stops; here it returns to waiting and triggers again on the next single hit.
// - A begin point keeps capture off from arming until its first match.
// - Stop-on-full with a begin point halts capture at the buffer end.
// - One begin point may pair with one halt point to capture a span.
// - A halt point stops capture after records-after-hit further records.
// - A freeze point stops like a halt, then stays stopped until resume.
// - At most one begin, halt and single point; up to four report and freeze.
// - With begin and halt armed, the first seen event counts as begin.
// - Any armed point forces both debug-mode bits to zero.
// - Pausing for a buffer read freezes capture state; it resumes unchanged.
// - Interrupt, link register and process identifier events are marked in records.
// - Without stop-on-full the write pointer wraps and overwrites the oldest records.
// - The records-after-hit count is sixteen bits, at most FFFF.
// - A freeze point on an instruction uses at least 0x10 tail records.
// - One record is taken per trace clock cycle into a 512 KB buffer.
`timescale 1ns/1ps
module trace_capture_ctrl
  import trace_cap_pkg::*;
(
  // Clock and reset
  input  wire logic                                REF_CLK,
  input  wire logic                                RESET,
  // AXI4-Lite slave
  input  wire logic [trace_cap_pkg::ADDR_W-1:0]    S_AXI_AWADDR,
  input  wire logic                                S_AXI_AWVALID,
  output logic                                     S_AXI_AWREADY,
  input  wire logic [trace_cap_pkg::DATA_W-1:0]    S_AXI_WDATA,
  input  wire logic [3:0]                          S_AXI_WSTRB,
  input  wire logic                                S_AXI_WVALID,
  output logic                                     S_AXI_WREADY,
  output logic [1:0]                               S_AXI_BRESP,
  output logic                                     S_AXI_BVALID,
  input  wire logic                                S_AXI_BREADY,
  input  wire logic [trace_cap_pkg::ADDR_W-1:0]    S_AXI_ARADDR,
  input  wire logic                                S_AXI_ARVALID,
  output logic                                     S_AXI_ARREADY,
  output logic [trace_cap_pkg::DATA_W-1:0]         S_AXI_RDATA,
  output logic [1:0]                               S_AXI_RRESP,
  output logic                                     S_AXI_RVALID,
  input  wire logic                                S_AXI_RREADY,
  // Trace port of the target
  input  wire logic                                TRACE_CLK,
  input  wire logic [trace_cap_pkg::TDATA_W-1:0]   TRACE_DATA,
  input  wire logic [trace_cap_pkg::NPOINT-1:0]    BP_MATCH,
  input  wire logic                                EVT_IRQ,
  input  wire logic                                EVT_LR,
  input  wire logic                                EVT_PID,
  // Buffer write port and debug-mode controls
  output logic                                     BUF_WE,
  output logic [trace_cap_pkg::BUF_AW-1:0]         BUF_ADDR,
  output logic [trace_cap_pkg::DATA_W-1:0]         BUF_DATA,
  output logic                                     INTERNAL_DEBUG_MODE_BIT,
  output logic                                     EXTERNAL_DEBUG_MODE_BIT
);
  import trace_cap_pkg::*;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [NPOINT-1:0] kind_vec(input point_cfg_t cfg, input logic [2:0] k);
    logic [NPOINT-1:0] v;
    v = '0;
    for (int i = 0; i < NPOINT; i++) begin
      v[i] = cfg[i][PT_EN_BIT] && (cfg[i][PT_KIND_LSB +: 3] == k);
    end
    return v;
  endfunction : kind_vec

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, input logic [DATA_W-1:0] n,
                                              input logic [3:0] s);
    logic [DATA_W-1:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic              tclk3_r;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      sync1_r <= '0;
      sync2_r <= '0;
      tclk3_r <= 1'b0;
    end else begin
      sync1_r <= {TRACE_CLK, EVT_PID, EVT_LR, EVT_IRQ, BP_MATCH, TRACE_DATA};
      sync2_r <= sync1_r;
      tclk3_r <= sync2_r[SYNC_W-1];
    end
  end

  // ****************************************
  // Register file and AXI4-Lite slave
  // ****************************************
  logic [DATA_W-1:0] ctrl_r, ctrl_nxt;
  logic [CNT_W-1:0]  after_r, after_nxt, ftail_r, ftail_nxt;
  point_cfg_t        pcfg_r, pcfg_nxt;
  logic              awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
  logic              arready_r, arready_nxt, rvalid_r, rvalid_nxt, resume_r, resume_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [DATA_W-1:0] wmerge;
  logic [3:0]        wstrb_r, wstrb_nxt;
  logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  cap_state_e        st_r;
  logic [BUF_AW-1:0] wptr_r;
  logic              full_r;

  always_comb begin
    ctrl_nxt    = ctrl_r;
    after_nxt   = after_r;
    ftail_nxt   = ftail_r;
    pcfg_nxt    = pcfg_r;
    awready_nxt = awready_r;
    wready_nxt  = wready_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    resume_nxt  = 1'b0;
    wmerge      = '0;
    if (S_AXI_AWVALID && awready_r) begin
      awaddr_nxt  = S_AXI_AWADDR;
      awready_nxt = 1'b0;
    end
    if (S_AXI_WVALID && wready_r) begin
      wdata_nxt  = S_AXI_WDATA;
      wstrb_nxt  = S_AXI_WSTRB;
      wready_nxt = 1'b0;
    end
    if (!awready_r && !wready_r && !bvalid_r) begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = RESP_OKAY;
      if (awaddr_r == CTRL_OFS) begin
        wmerge     = merge(ctrl_r, wdata_r, wstrb_r);
        ctrl_nxt   = (wmerge & CTRL_RESET) | {27'h000_0000, 1'b0, 1'b0,
                     wmerge[CTRL_PAUSE_BIT:CTRL_STOPFULL_BIT], 1'b0};
        resume_nxt = wstrb_r[0] && wdata_r[CTRL_RESUME_BIT];
      end else if (awaddr_r == AFTER_OFS) begin
        wmerge    = merge({16'h0000, after_r}, wdata_r, wstrb_r);
        after_nxt = wmerge[CNT_W-1:0];
      end else if (awaddr_r == TAIL_OFS) begin
        wmerge    = merge({16'h0000, ftail_r}, wdata_r, wstrb_r);
        ftail_nxt = wmerge[CNT_W-1:0];
      end else if (awaddr_r[7:4] == POINT_OFS[7:4]) begin
        wmerge                  = merge({27'h000_0000, pcfg_r[awaddr_r[3:2]]}, wdata_r, wstrb_r);
        pcfg_nxt[awaddr_r[3:2]] = wmerge[PT_W-1:0];
      end else if (awaddr_r != STATUS_OFS && awaddr_r != WPTR_OFS) begin
        bresp_nxt = RESP_SLVERR;
      end
    end
    if (bvalid_r && S_AXI_BREADY) begin
      bvalid_nxt  = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt  = 1'b1;
    end
    if (S_AXI_ARVALID && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rresp_nxt   = RESP_OKAY;
      rdata_nxt   = '0;
      if (S_AXI_ARADDR == CTRL_OFS) begin
        rdata_nxt = ctrl_r;
      end else if (S_AXI_ARADDR == STATUS_OFS) begin
        rdata_nxt = {27'h000_0000, full_r, 1'b0, st_r};
      end else if (S_AXI_ARADDR == AFTER_OFS) begin
        rdata_nxt = {16'h0000, after_r};
      end else if (S_AXI_ARADDR == TAIL_OFS) begin
        rdata_nxt = {16'h0000, ftail_r};
      end else if (S_AXI_ARADDR == WPTR_OFS) begin
        rdata_nxt = {15'h0000, wptr_r};
      end else if (S_AXI_ARADDR[7:4] == POINT_OFS[7:4]) begin
        rdata_nxt = {27'h000_0000, pcfg_r[S_AXI_ARADDR[3:2]]};
      end else begin
        rresp_nxt = RESP_SLVERR;
      end
    end
    if (rvalid_r && S_AXI_RREADY) begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ctrl_r    <= CTRL_RESET;
      after_r   <= '0;
      ftail_r   <= '0;
      pcfg_r    <= '0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
      resume_r  <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      after_r   <= after_nxt;
      ftail_r   <= ftail_nxt;
      pcfg_r    <= pcfg_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      resume_r  <= resume_nxt;
    end
  end

  // ****************************************
  // Point decode
  // ****************************************
  logic [NPOINT-1:0] kv_begin, kv_halt, kv_single, kv_freeze, kv_report, data_vec, m;
  logic              cfg_err, have_begin, begin_h, halt_h, single_h, freeze_h, fcode_h, report_h, evt_any;
  logic              tick, pause, stopfull, any_en;
  logic [CNT_W-1:0]  pt_eff;

  always_comb begin
    for (int i = 0; i < NPOINT; i++) begin
      data_vec[i] = pcfg_r[i][PT_DATA_BIT];
    end
    kv_begin  = kind_vec(pcfg_r, KIND_BEGIN);
    kv_halt   = kind_vec(pcfg_r, KIND_HALT);
    kv_single = kind_vec(pcfg_r, KIND_SINGLE);
    kv_freeze = kind_vec(pcfg_r, KIND_FREEZE);
    kv_report = kind_vec(pcfg_r, KIND_REPORT) & ~data_vec;
    cfg_err   = ($countones(kv_begin) > 1) || ($countones(kv_halt) > 1) ||
                ($countones(kv_single) > 1);
    m          = sync2_r[TDATA_W +: NPOINT] & {NPOINT{!cfg_err}};
    any_en     = |(kv_begin | kv_halt | kv_single | kv_freeze | kv_report);
    have_begin = |kv_begin && !cfg_err;
    begin_h    = |(m & kv_begin);
    halt_h     = |(m & kv_halt);
    single_h   = |(m & kv_single);
    freeze_h   = |(m & kv_freeze);
    fcode_h    = |(m & kv_freeze & ~data_vec);
    report_h   = |(m & kv_report);
    evt_any    = |sync2_r[TDATA_W+NPOINT +: 3];
    pause      = ctrl_r[CTRL_PAUSE_BIT];
    stopfull   = ctrl_r[CTRL_STOPFULL_BIT];
    tick       = sync2_r[SYNC_W-1] && !tclk3_r && !pause;
    pt_eff     = (fcode_h && ftail_r < FREEZE_MIN) ? FREEZE_MIN : ftail_r;
  end

  // ****************************************
  // Capture state machine
  // ****************************************
  cap_state_e        st_nxt, goal_r, goal_nxt, ld_goal;
  logic [CNT_W-1:0]  tail_r, tail_nxt, ld_cnt;
  logic [BUF_AW-1:0] wptr_nxt;
  logic              full_nxt, we_nxt, cap, ld, idm_nxt, edm_nxt;
  logic [DATA_W-1:0] rec;

  always_comb begin
    st_nxt   = st_r;
    goal_nxt = goal_r;
    tail_nxt = tail_r;
    wptr_nxt = wptr_r;
    full_nxt = full_r;
    we_nxt   = 1'b0;
    cap      = (st_r == ST_RUN) || (st_r == ST_TAIL);
    ld       = 1'b0;
    ld_cnt   = after_r;
    ld_goal  = ST_WAIT;
    rec      = {begin_h | halt_h | single_h | freeze_h | report_h, report_h,
                sync2_r[TDATA_W+NPOINT +: 3], 3'h0, sync2_r[TDATA_W-1:0]};
    idm_nxt  = ctrl_r[CTRL_IDM_BIT] && !any_en;
    edm_nxt  = ctrl_r[CTRL_EDM_BIT] && !any_en;
    if (resume_r) begin
      st_nxt   = (have_begin || |kv_single) ? ST_WAIT : ST_RUN;
      tail_nxt = '0;
      wptr_nxt = '0;
      full_nxt = 1'b0;
    end else if (tick) begin
      unique case (st_r)
        ST_WAIT: begin
          if (single_h) begin
            cap = 1'b1;
            ld  = 1'b1;
          end else if (begin_h || (halt_h && have_begin)) begin
            cap    = 1'b1;
            st_nxt = ST_RUN;
          end
        end
        ST_RUN: begin
          if (freeze_h) begin
            ld      = 1'b1;
            ld_cnt  = pt_eff;
            ld_goal = ST_FROZEN;
          end else if (halt_h || single_h) begin
            ld      = 1'b1;
            ld_goal = (have_begin || single_h) ? ST_WAIT : ST_STOP;
          end
        end
        ST_TAIL: begin
          if (tail_r == 16'h0001) begin
            st_nxt = goal_r;
          end else begin
            tail_nxt = tail_r - 16'h0001;
          end
        end
        ST_STOP, ST_FROZEN: begin
        end
      endcase
      if (ld) begin
        tail_nxt = ld_cnt;
        goal_nxt = ld_goal;
        st_nxt   = (ld_cnt == '0) ? ld_goal : ST_TAIL;
      end
      if (cap || (report_h || evt_any) && st_r == ST_WAIT) begin
        we_nxt   = 1'b1;
        wptr_nxt = wptr_r + {{(BUF_AW-1){1'b0}}, 1'b1};
        if (&wptr_r) begin
          full_nxt = 1'b1;
          if (stopfull && have_begin) begin
            st_nxt = ST_STOP;
          end
        end
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      st_r     <= ST_RUN;
      goal_r   <= ST_WAIT;
      tail_r   <= '0;
      wptr_r   <= '0;
      full_r   <= 1'b0;
      BUF_WE   <= 1'b0;
      BUF_ADDR <= '0;
      BUF_DATA <= '0;
      INTERNAL_DEBUG_MODE_BIT <= 1'b1;
      EXTERNAL_DEBUG_MODE_BIT <= 1'b1;
    end else begin
      st_r     <= st_nxt;
      goal_r   <= goal_nxt;
      tail_r   <= tail_nxt;
      wptr_r   <= wptr_nxt;
      full_r   <= full_nxt;
      BUF_WE   <= we_nxt;
      BUF_ADDR <= wptr_r;
      BUF_DATA <= rec;
      INTERNAL_DEBUG_MODE_BIT <= idm_nxt;
      EXTERNAL_DEBUG_MODE_BIT <= edm_nxt;
    end
  end

  assign S_AXI_AWREADY = awready_r;
  assign S_AXI_WREADY  = wready_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_BRESP   = bresp_r;
  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_RVALID  = rvalid_r;
  assign S_AXI_RDATA   = rdata_r;
  assign S_AXI_RRESP   = rresp_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  sequence single_hit_s;
    !resume_r && tick && st_r == ST_WAIT && single_h && after_r == '0 && !(stopfull && &wptr_r);
  endsequence
  sequence paused_s;
    (pause && !resume_r) [*2];
  endsequence

  dbg_mode_off_a: assert property (any_en |=> !INTERNAL_DEBUG_MODE_BIT && !EXTERNAL_DEBUG_MODE_BIT)
    else $error("debug mode bits not cleared by armed point");
  begin_quiet_a: assert property (!resume_r && tick && st_r == ST_WAIT && !(|m) && !evt_any |=>
    !BUF_WE && st_r == ST_WAIT) else $error("record written before begin match");
  begin_start_a: assert property (!resume_r && tick && st_r == ST_WAIT && begin_h && !single_h &&
    !(stopfull && &wptr_r) |=> BUF_WE && st_r == ST_RUN) else $error("begin match did not start capture");
  single_once_a: assert property (single_hit_s |=> BUF_WE && BUF_DATA[REC_MATCH_BIT] && st_r == ST_WAIT)
    else $error("single hit did not record exactly the match");
  frozen_hold_a: assert property (st_r == ST_FROZEN && !resume_r |=> st_r == ST_FROZEN)
    else $error("frozen capture left without resume");
  freeze_floor_a: assert property (!resume_r && tick && st_r == ST_RUN && fcode_h && ftail_r < FREEZE_MIN
    |=> st_r == ST_TAIL && tail_r == FREEZE_MIN) else $error("freeze tail not raised to minimum");
  pause_hold_a: assert property (paused_s |-> $stable(st_r) && $stable(wptr_r))
    else $error("capture state moved while paused");
  wrap_a: assert property (!resume_r && we_nxt && &wptr_r && !stopfull |=> wptr_r == '0 && full_r)
    else $error("write pointer did not wrap");
  stop_full_a: assert property (!resume_r && we_nxt && &wptr_r && stopfull && have_begin |=>
    st_r == ST_STOP ##1 !BUF_WE) else $error("capture did not halt at buffer end");
  resume_a: assert property (resume_r |=> st_r != ST_FROZEN && wptr_r == '0 && !full_r)
    else $error("resume did not re-arm capture");
  report_a: assert property (!resume_r && tick && st_r == ST_WAIT && report_h |=>
    BUF_WE && BUF_DATA[REC_REPORT_BIT]) else $error("report pattern not stored");

endmodule : trace_capture_ctrl
